/* File: hdl/asrp_pkg.sv */
/*
 * Constants shared by the serial result port of the converter: word layout,
 * configuration word layout, result range and state encoding.
 * Assumes a SystemVerilog-2012 compiler; holds definitions only.
 */

package asrp_pkg;

   // ----------------------------------------------------------------------
   // Output word layout.
   // ----------------------------------------------------------------------
   localparam int WORD_BITS = 24;
   localparam int EOC_POS = 23;
   localparam int FILLER_POS = 22;
   localparam int POLARITY_POS = 21;
   localparam int RESULT_MSB_POS = 20;
   localparam int RESULT_LSB_POS = 4;
   localparam int CODE_BITS = 18;
   localparam logic [4:0] CNT_LAST = 5'h17;
   localparam logic [4:0] CNT_DONE = 5'h18;
   localparam logic [3:0] TAIL_ZEROS = 4'h0;

   // ----------------------------------------------------------------------
   // Result range: raw conversion value is two's complement, one step per LSB.
   // ----------------------------------------------------------------------
   localparam int RAW_BITS = 20;
   localparam logic signed [19:0] RAW_POS_CLAMP = 20'sh10000;
   localparam logic signed [19:0] RAW_NEG_CLAMP = -20'sh10001;
   localparam logic signed [19:0] CODE_OFFSET = 20'sh20000;

   // ----------------------------------------------------------------------
   // Input configuration word layout.
   // ----------------------------------------------------------------------
   localparam int CFG_BITS = 16;
   localparam logic [4:0] CNT_CFG_LAST = 5'h0f;
   localparam int PRE_MSB = 15;
   localparam int PRE_LSB = 13;
   localparam logic [2:0] PRE_LOAD = 3'h5;
   localparam int CHAN_MSB = 12;
   localparam int CHAN_LSB = 8;
   localparam int EN2_POS = 7;
   localparam int SETUP_MSB = 6;
   localparam int SETUP_LSB = 0;
   localparam logic [4:0] CHAN_RESET = 5'h00;
   localparam logic [6:0] SETUP_RESET = 7'h00;

   // ----------------------------------------------------------------------
   // Port sequencing states.
   // ----------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_START = 2'b00,
      ST_CONV = 2'b01,
      ST_SLEEP = 2'b10,
      ST_OUTPUT = 2'b11
   } asrp_state_e;

endpackage : asrp_pkg

/* File: hdl/asrp_sync.sv */
/*
 * Two flip-flop level synchroniser into the i_clk domain.
 * Assumes the input is a level that stays put for several i_clk cycles.
 */

`timescale 1ns/100ps
`default_nettype none

module asrp_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_async,
   output logic o_sync
);

   logic meta_q;

   // ----------------------------------------------------------------------
   // Synchroniser chain; the first stage feeds only the second.
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         meta_q <= RESET_VAL;
         o_sync <= RESET_VAL;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule : asrp_sync

`default_nettype wire

/* File: hdl/asrp_port.sv */
/*
 * Serial result and configuration port of a delta-sigma converter.
 * The i_clk side sequences conversions and holds the result word; the
 * i_sck side shifts the word out and the configuration word in.
 * Assumes an external serial clock held low at each falling edge of chip
 * select, and a converter core that answers a start pulse with one done
 * pulse carrying a two's complement raw value on i_clk.
 */

`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Data output high impedance while select high.
// - Select low outside output phase shows end flag.
// - End flag reads high during conversion.
// - End flag drops as soon as conversion completes.
// - Sleep after conversion until select pulled low.
// - New conversion after all 24 bits read.
// - Select high mid-transfer aborts, starts conversion.
// - Input bits sampled on rising clock, select low.
// - Result word is 24 bits, MSB first.
// - Bit 22 filler is always low.
// - Polarity bit high for zero or positive.
// - Bits 21,20 mark over and under range.
// - Bits 20 to 4 carry result, LSB bit 4.
// - Bits 3 to 0 always low.
// - Select high ignores serial clock entirely.
// - Bit 22 on first falling, bit 0 on 23rd.
// - After bit 0, output shows next end flag.
// - Out-of-range results clamp one step beyond full scale.
// - Output changes on falling, input sampled rising.
// - Input word is 16 bits long.
// - Preamble 101 loads channel; 000/100 keep it.
module asrp_port (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_sck,
   input wire logic i_cs_b,
   input wire logic i_sdi,
   input wire logic i_conv_done,
   input wire logic signed [asrp_pkg::RAW_BITS-1:0] i_conv_raw,
   output logic o_sdo,
   output logic o_sdo_oe_b,
   output logic o_conv_start,
   output logic o_sleep,
   output logic [asrp_pkg::CHAN_MSB-asrp_pkg::CHAN_LSB:0] o_chan,
   output logic [asrp_pkg::SETUP_MSB-asrp_pkg::SETUP_LSB:0] o_setup
);
   import asrp_pkg::*;

   // ----------------------------------------------------------------------
   // Result coding.
   // ----------------------------------------------------------------------

   // Clamps the raw value and turns it into the offset code of bits 21..4.
   function automatic logic [CODE_BITS-1:0] asrp_offset_code(input logic signed [RAW_BITS-1:0] raw);
      logic signed [RAW_BITS-1:0] lim;
      logic signed [RAW_BITS-1:0] sum;
      lim = raw;
      sum = '0;
      if (raw > RAW_POS_CLAMP)
      begin
         lim = RAW_POS_CLAMP;
      end
      else if (raw < RAW_NEG_CLAMP)
      begin
         lim = RAW_NEG_CLAMP;
      end
      sum = lim + CODE_OFFSET;
      return sum[CODE_BITS-1:0];
   endfunction : asrp_offset_code

   // ----------------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------------
   asrp_state_e state_q;
   asrp_state_e state_d;
   logic [WORD_BITS-1:0] word_q;
   logic eoc_q;
   logic out_phase_q;
   logic started_q;
   logic conv_start_q;
   logic sleep_q;
   logic sdo_oe_b_q;
   logic [CHAN_MSB-CHAN_LSB:0] chan_q;
   logic [SETUP_MSB-SETUP_LSB:0] setup_q;
   logic cs_s;
   logic start_tog_s;
   logic done_tog_s;
   logic load_tog_s;
   logic start_tog_s_q;
   logic done_tog_s_q;
   logic load_tog_s_q;
   logic start_evt;
   logic done_evt;
   logic load_evt;
   logic [4:0] rise_cnt_q;
   logic [CFG_BITS-1:0] cfg_sh_q;
   // Link side has no reset; toggles power up low to match the synchronisers.
   logic start_tog_q = 1'b0;
   logic done_tog_q = 1'b0;
   logic load_tog_q = 1'b0;
   logic sdo_sh_q;

   // ----------------------------------------------------------------------
   // Crossings from the serial clock side and the pin into i_clk.
   // ----------------------------------------------------------------------
   asrp_sync #(.RESET_VAL(1'b1)) u_sync_cs (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async(i_cs_b),
      .o_sync(cs_s)
   );

   asrp_sync #(.RESET_VAL(1'b0)) u_sync_start (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async(start_tog_q),
      .o_sync(start_tog_s)
   );

   asrp_sync #(.RESET_VAL(1'b0)) u_sync_done (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async(done_tog_q),
      .o_sync(done_tog_s)
   );

   asrp_sync #(.RESET_VAL(1'b0)) u_sync_load (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async(load_tog_q),
      .o_sync(load_tog_s)
   );

   // Toggle history turns each synchronised toggle into a one-cycle event.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         start_tog_s_q <= 1'b0;
         done_tog_s_q <= 1'b0;
         load_tog_s_q <= 1'b0;
      end
      else
      begin
         start_tog_s_q <= start_tog_s;
         done_tog_s_q <= done_tog_s;
         load_tog_s_q <= load_tog_s;
      end
   end

   assign start_evt = start_tog_s ^ start_tog_s_q;
   assign done_evt = done_tog_s ^ done_tog_s_q;
   assign load_evt = load_tog_s ^ load_tog_s_q;

   // ----------------------------------------------------------------------
   // Conversion sequencing on i_clk.
   // ----------------------------------------------------------------------

   // Next state: convert, then sleep or present data, then convert again.
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_START:
         begin
            state_d = ST_CONV;
         end
         ST_CONV:
         begin
            if (i_conv_done)
            begin
               state_d = cs_s ? ST_SLEEP : ST_OUTPUT;
            end
         end
         ST_SLEEP:
         begin
            if (!cs_s)
            begin
               state_d = ST_OUTPUT;
            end
         end
         ST_OUTPUT:
         begin
            if (done_evt)
            begin
               state_d = ST_START;
            end
            else if (cs_s && started_q)
            begin
               state_d = ST_START;
            end
            else if (cs_s)
            begin
               state_d = ST_SLEEP;
            end
         end
         default:
         begin
            state_d = ST_START;
         end
      endcase
   end

   // State register.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         state_q <= ST_START;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Remembers that the host has begun clocking the present word out.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         started_q <= 1'b0;
      end
      else if (state_q != ST_OUTPUT)
      begin
         started_q <= 1'b0;
      end
      else if (start_evt)
      begin
         started_q <= 1'b1;
      end
   end

   // Captures the finished result as the full 24-bit output word.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         word_q <= '0;
      end
      else if (state_q == ST_CONV && i_conv_done)
      begin
         word_q <= {1'b0, 1'b0, asrp_offset_code(i_conv_raw), TAIL_ZEROS};
      end
   end

   // End flag is high from the start of a conversion until its done pulse.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         eoc_q <= 1'b1;
      end
      else
      begin
         eoc_q <= (state_d == ST_START) || (state_d == ST_CONV);
      end
   end

   // Status and start outputs.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         conv_start_q <= 1'b0;
         sleep_q <= 1'b0;
         out_phase_q <= 1'b0;
         sdo_oe_b_q <= 1'b1;
      end
      else
      begin
         conv_start_q <= (state_q == ST_START);
         sleep_q <= (state_d == ST_SLEEP);
         out_phase_q <= (state_d == ST_OUTPUT);
         sdo_oe_b_q <= cs_s;
      end
   end

   // Loads channel when the configuration preamble asks for it, and setup too only if the EN2_POS bit is set.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         chan_q <= CHAN_RESET;
         setup_q <= SETUP_RESET;
      end
      else if (load_evt && cfg_sh_q[PRE_MSB:PRE_LSB] == PRE_LOAD)
      begin
         chan_q <= cfg_sh_q[CHAN_MSB:CHAN_LSB];
         if (cfg_sh_q[EN2_POS])
         begin
            setup_q <= cfg_sh_q[SETUP_MSB:SETUP_LSB];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Serial clock side; chip select high clears the edge count and output bit and blocks all edges.
   // ----------------------------------------------------------------------

   // Counts rising edges of the frame and holds the count at 24.
   always_ff @(posedge i_sck or posedge i_cs_b)
   begin
      if (i_cs_b)
      begin
         rise_cnt_q <= 5'h00;
      end
      else if (rise_cnt_q != CNT_DONE)
      begin
         rise_cnt_q <= rise_cnt_q + 5'h01;
      end
   end

   // Input word is taken MSB first on the first 16 rising edges.
   always_ff @(posedge i_sck)
   begin
      if (!i_cs_b && rise_cnt_q <= CNT_CFG_LAST)
      begin
         cfg_sh_q <= {cfg_sh_q[CFG_BITS-2:0], i_sdi};
      end
   end

   // Event toggles: first edge, 16th edge and 24th edge of the frame.
   always_ff @(posedge i_sck)
   begin
      if (!i_cs_b && rise_cnt_q == 5'h00)
      begin
         start_tog_q <= ~start_tog_q;
      end
      if (!i_cs_b && rise_cnt_q == CNT_CFG_LAST)
      begin
         load_tog_q <= ~load_tog_q;
      end
      if (!i_cs_b && rise_cnt_q == CNT_LAST)
      begin
         done_tog_q <= ~done_tog_q;
      end
   end

   // Output bit moves on each falling edge; word is stable in output phase.
   always_ff @(negedge i_sck or posedge i_cs_b)
   begin
      if (i_cs_b)
      begin
         sdo_sh_q <= 1'b0;
      end
      else if (rise_cnt_q >= CNT_DONE)
      begin
         sdo_sh_q <= 1'b1;
      end
      else
      begin
         sdo_sh_q <= word_q[5'(EOC_POS) - rise_cnt_q];
      end
   end

   // ----------------------------------------------------------------------
   // Pin drive: data bits in output phase, otherwise the end flag.
   // ----------------------------------------------------------------------
   assign o_sdo = out_phase_q ? sdo_sh_q : eoc_q;
   assign o_sdo_oe_b = sdo_oe_b_q;
   assign o_conv_start = conv_start_q;
   assign o_sleep = sleep_q;
   assign o_chan = chan_q;
   assign o_setup = setup_q;

endmodule : asrp_port

`default_nettype wire

/* File: tb/asrp_monitor.sv */
/* Assertions on the ports of asrp_port, bound to it.
   Assumes the serial clock idles low outside frames. */
`timescale 1ns/100ps
`default_nettype none
module asrp_monitor (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_sck,
   input wire logic i_cs_b,
   input wire logic i_conv_done,
   input wire logic o_sdo,
   input wire logic o_sdo_oe_b,
   input wire logic o_conv_start,
   input wire logic o_sleep
);
   logic [4:0] rise_q;
   // Counts serial clock rises in a frame; select high clears it.
   always_ff @(posedge i_sck or posedge i_cs_b)
   begin
      if (i_cs_b)
         rise_q <= 5'h00;
      else if (rise_q != 5'h1f)
         rise_q <= rise_q + 5'h01;
   end
   property p_hiz;
      @(posedge i_clk) disable iff (!i_rst_b) i_cs_b [*4] |-> o_sdo_oe_b;
   endproperty
   a_hiz: assert property (p_hiz) else $error("sdo driven while deselected");
   property p_busy;
      @(posedge i_clk) disable iff (!i_rst_b) o_conv_start ##[3:12] !o_sdo_oe_b |-> o_sdo;
   endproperty
   a_busy: assert property (p_busy) else $error("end flag low while converting");
   property p_fall;
      @(posedge i_clk) disable iff (!i_rst_b) i_conv_done && o_sdo && !o_sdo_oe_b && !i_cs_b |=> !o_sdo;
   endproperty
   a_fall: assert property (p_fall) else $error("end flag late");
   property p_sleep;
      @(posedge i_clk) disable iff (!i_rst_b) o_sleep && i_cs_b |=> o_sleep && !o_conv_start;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep left while deselected");
   property p_restart;
      @(posedge i_clk) disable iff (!i_rst_b) $rose(rise_q == 5'h18) |-> ##[0:8] o_conv_start;
   endproperty
   a_restart: assert property (p_restart) else $error("no start after full word");
   property p_abort;
      @(posedge i_clk) disable iff (!i_rst_b)
         $rose(i_cs_b) && $past(rise_q) inside {[5'h01:5'h17]} |-> ##[1:8] o_conv_start;
   endproperty
   a_abort: assert property (p_abort) else $error("no start after abort");
   property p_filler;
      @(posedge i_sck) disable iff (i_cs_b) rise_q == 5'h01 |-> !o_sdo;
   endproperty
   a_filler: assert property (p_filler) else $error("filler bit high");
   property p_tail;
      @(posedge i_sck) disable iff (i_cs_b) rise_q >= 5'h14 && rise_q <= 5'h17 |-> !o_sdo;
   endproperty
   a_tail: assert property (p_tail) else $error("tail bit high");
   property p_next;
      @(posedge i_clk) disable iff (!i_rst_b) rise_q == 5'h18 && !i_sck && !i_cs_b |-> o_sdo;
   endproperty
   a_next: assert property (p_next) else $error("next end flag missing");
   c_word: cover property (@(posedge i_clk) $rose(rise_q == 5'h18));
   c_abort: cover property (@(posedge i_clk) $rose(i_cs_b) && $past(rise_q) == 5'h0a);
   c_sleep: cover property (@(posedge i_clk) $rose(o_sleep));
endmodule : asrp_monitor
bind asrp_port asrp_monitor asrp_monitor_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sck(i_sck),
   .i_cs_b(i_cs_b), .i_conv_done(i_conv_done), .o_sdo(o_sdo), .o_sdo_oe_b(o_sdo_oe_b),
   .o_conv_start(o_conv_start), .o_sleep(o_sleep));
`default_nettype wire

/* File: tb/asrp_host.sv */
/* Host model: drives select, serial clock and serial data in.
   Assumes the port under test answers on its data output. */
`timescale 1ns/100ps
`default_nettype none
module asrp_host (
   output logic o_sck,
   output logic o_cs_b,
   output logic o_sdi,
   input wire logic i_sdo,
   input wire logic i_sdo_oe_b
);
   // Idle levels; the clock is held low to pick external mode.
   initial
   begin
      o_sck = 1'b0;
      o_cs_b = 1'b1;
      o_sdi = 1'b0;
   end
   // Moves the select line alone.
   task automatic select(input logic v);
      o_cs_b = v;
   endtask : select
   // Pulses the clock without touching select.
   task automatic pulse(input int n);
      repeat (n)
      begin
         #3 o_sck = 1'b1;
         #3 o_sck = 1'b0;
      end
   endtask : pulse
   // One frame: wait for the end flag low, then n clock pulses.
   task automatic frame(input logic [15:0] cfg, input int n, output logic [23:0] w, output logic tl);
      int t;
      t = 0;
      w = 24'h000000;
      o_cs_b = 1'b0;
      o_sdi = cfg[15];
      while ((i_sdo_oe_b !== 1'b0 || i_sdo !== 1'b0) && t < 400)
      begin
         #3;
         t++;
      end
      for (int k = 0; k < n; k++)
      begin
         #3 o_sck = 1'b1;
         w = {w[22:0], i_sdo};
         #3 o_sck = 1'b0;
         o_sdi = (k < 15) ? cfg[14 - k] : ~o_sdi;
      end
      #1 tl = i_sdo;
      #9 o_cs_b = 1'b1;
      o_sdi = ~o_sdi;
   endtask : frame
endmodule : asrp_host
`default_nettype wire

/* File: tb/tb_top.sv */
/* Bench for asrp_port with a host model and a converter core model.
   Assumes design, checker and host files are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import asrp_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic conv_done = 1'b0;
   logic signed [RAW_BITS-1:0] conv_raw = 20'sh00000;
   logic sck, cs_b, sdi, sdo, sdo_oe_b, conv_start, sleep, tl;
   logic [4:0] chan;
   logic [6:0] setup;
   logic [23:0] w;
   int error_cnt = 0, cmp_count = 0, starts = 0, busy = 0, cyc = 0, next_raw = 0;
   // System clock.
   always #5 clk = ~clk;
   asrp_port asrp_port_inst (.i_clk(clk), .i_rst_b(rst_b), .i_sck(sck), .i_cs_b(cs_b), .i_sdi(sdi),
      .i_conv_done(conv_done), .i_conv_raw(conv_raw), .o_sdo(sdo), .o_sdo_oe_b(sdo_oe_b),
      .o_conv_start(conv_start), .o_sleep(sleep), .o_chan(chan), .o_setup(setup));
   asrp_host asrp_host_inst (.o_sck(sck), .o_cs_b(cs_b), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe_b(sdo_oe_b));
   // Core answers each start after 20 cycles; a cycle ceiling cuts hangs.
   always @(posedge clk)
   begin
      conv_done <= 1'b0;
      cyc <= cyc + 1;
      if (conv_start === 1'b1)
      begin
         busy <= 20;
         starts <= starts + 1;
      end
      else if (busy > 0)
      begin
         busy <= busy - 1;
         conv_done <= (busy == 1);
         conv_raw <= 20'(next_raw);
      end
      if (cyc == 6000)
      begin
         error_cnt++;
         close_out();
      end
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Expected word: clamp, then offset code in bits 21 to 4.
   function automatic logic [23:0] exp_word(input int raw);
      int c;
      c = (raw > 32'sh10000) ? 32'sh10000 : (raw < -32'sh10001) ? -32'sh10001 : raw;
      c = c + 32'sh20000;
      return {2'b00, c[17:0], 4'h0};
   endfunction : exp_word
   task automatic wait_sleep();
      int n;
      n = 0;
      while (sleep !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      check(24'(sleep), 24'h000001);
   endtask : wait_sleep
   task automatic t_reset();
      repeat (6) @(posedge clk);
      check(24'({sdo_oe_b, sleep, conv_start, chan, setup}), 24'h004000);
      rst_b <= 1'b1;
      $display("reset test done");
   endtask : t_reset
   task automatic t_format();
      int v[8] = '{32'sh0, -32'sh1, 32'sh0ffff, -32'sh10000, 32'sh10000, -32'sh10001, 32'sh186a0, -32'sh186a0};
      int s;
      for (int i = 0; i < 8; i++)
      begin
         next_raw = v[i];
         wait_sleep();
         check(24'(sdo_oe_b), 24'h000001);
         s = starts;
         asrp_host_inst.frame(16'h0000, 24, w, tl);
         check(w, exp_word(v[i]));
         check(24'(tl), 24'h000001);
         repeat (8) @(negedge clk);
         check(24'(starts - s), 24'h000001);
      end
      $display("format test done");
   endtask : t_format
   task automatic t_config();
      logic [15:0] cfg[4] = '{16'ha7da, 16'ha211, 16'h9fff, 16'h1fff};
      logic [11:0] exp[4] = '{12'h3da, 12'h15a, 12'h15a, 12'h15a};
      for (int i = 0; i < 4; i++)
      begin
         wait_sleep();
         asrp_host_inst.frame(cfg[i], 24, w, tl);
         repeat (6) @(negedge clk);
         check(24'({chan, setup}), 24'(exp[i]));
      end
      $display("config test done");
   endtask : t_config
   task automatic t_abort();
      int s;
      wait_sleep();
      s = starts;
      asrp_host_inst.pulse(5);
      repeat (6) @(negedge clk);
      check(24'({sdo_oe_b, sleep}), 24'h000003);
      asrp_host_inst.frame(16'h0000, 0, w, tl);
      repeat (8) @(negedge clk);
      check(24'({sleep, 8'(starts - s)}), 24'h000100);
      asrp_host_inst.frame(16'h0000, 10, w, tl);
      repeat (10) @(negedge clk);
      check(24'(starts - s), 24'h000001);
      asrp_host_inst.select(1'b0);
      repeat (4) @(negedge clk);
      check(24'({sdo_oe_b, sdo}), 24'h000001);
      for (s = 0; s < 40 && sdo !== 1'b0; s++)
         @(negedge clk);
      check(24'(sdo), 24'h000000);
      asrp_host_inst.frame(16'h0000, 24, w, tl);
      check(w, exp_word(next_raw));
      $display("abort test done");
   endtask : t_abort
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   // Main sequence.
   initial
   begin
      t_reset();
      t_format();
      t_config();
      t_abort();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
